// [msc_cap_regs.sv]
// Purpose: Read-only MSI pending status, PCI Express capability header and
//          lower device capability registers of one switch port.
// Assumes: Configuration reads and writes arrive as one-cycle strobes with
//          a byte offset; straps are stable around reset release.
// Notes:   Answers come one clock after the strobe.
`timescale 1ns/10ps
`default_nettype none
`include "msc_defines.svh"
module msc_cap_regs import msc_pkg::*; (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic cfg_rd,
   input wire logic cfg_wr,
   input wire logic [11:0] cfg_addr,
   input wire logic [31:0] cfg_wdata,
   output logic [31:0] cfg_rdata,
   output logic cfg_rd_ack,
   output logic cfg_wr_ack,
   input wire logic preload_wr,
   input wire logic [11:0] preload_addr,
   input wire logic [31:0] preload_wdata,
   input wire logic [31:0] msi_ctrl_word,
   input wire logic virtual_switch_mode,
   input wire logic bridged_isolation_mode,
   input wire logic isolation_vif,
   input wire logic port_zero,
   input wire logic upstream_port,
   input wire logic mgmt_port,
   input wire logic [3:0] port_count,
   input wire logic hp_evt,
   input wire logic link_err_evt,
   input wire logic link_dll_evt,
   input wire logic link_msg_evt,
   input wire logic gpio_evt,
   input wire logic db_evt,
   input wire logic mdb_evt,
   input wire logic mls_evt
);
   msc_regs_s st_q;
   msc_regs_s st_d;
   logic cap64;
   logic sts_hit;
   logic [31:0] cap_hdr;
   logic [31:0] dev_cap;
   logic [2:0] pre_mps;

   msc_sts_if sif ();

   assign sif.mme = msi_ctrl_word[`MSC_MME_MSB:`MSC_MME_LSB]; // RULE17
   assign sif.vs_mode = virtual_switch_mode;
   assign sif.nt_mode = bridged_isolation_mode;
   assign sif.nt_vif = isolation_vif;
   assign sif.port_zero = port_zero;
   assign sif.upstream = st_q.upstream;
   assign sif.mgmt = mgmt_port;
   assign sif.hp_evt = hp_evt;
   assign sif.link_err_evt = link_err_evt;
   assign sif.link_dll_evt = link_dll_evt;
   assign sif.link_msg_evt = link_msg_evt;
   assign sif.gpio_evt = gpio_evt;
   assign sif.db_evt = db_evt;
   assign sif.mdb_evt = mdb_evt;
   assign sif.mls_evt = mls_evt;

   msc_pend_status u_pend (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .sif(sif)
   );

   // Codes above 2048 bytes have no meaning and are never stored.
   function automatic logic mps_valid(input logic [2:0] code);
      return code <= `MSC_MPS_MAX_CODE; // RULE14
   endfunction

   always_comb begin
      cap64 = msi_ctrl_word[`MSC_CAP64_BIT];
      sts_hit = cap64 ? (cfg_addr == `MSC_OFF_STS_64) :
         (cfg_addr == `MSC_OFF_STS_32); // RULE18
      cap_hdr = '0;
      cap_hdr[7:0] = `MSC_CAP_ID; // RULE7
      cap_hdr[15:8] = `MSC_NEXT_PTR; // RULE8
      cap_hdr[19:16] = `MSC_CAP_VER; // RULE9
      cap_hdr[23:20] = st_q.upstream ? `MSC_TYPE_UP : `MSC_TYPE_DN; // RULE10
      cap_hdr[`MSC_SLOT_BIT] = !st_q.upstream && st_q.slot_impl; // RULE11
      cap_hdr[29:25] = `MSC_MSG_NUM; // RULE12
      dev_cap = '0;
      dev_cap[2:0] = st_q.mps;
      dev_cap[4:3] = `MSC_PHANTOM; // RULE15
      dev_cap[5] = `MSC_EXT_TAG; // RULE15
      dev_cap[8:6] = `MSC_LAT_L0S; // RULE16
      dev_cap[11:9] = `MSC_LAT_L1; // RULE16
      dev_cap[14:12] = `MSC_DEVCAP_RSVD;
      dev_cap[15] = `MSC_ROLE_ERR;
      pre_mps = preload_wdata[2:0];

      st_d = st_q;
      st_d.rd_ack = cfg_rd;
      st_d.wr_ack = cfg_wr && !cfg_rd; // RULE19
      if (!st_q.strap_done) begin
         // Straps are caught on the first edge after reset release.
         st_d.strap_done = 1'b1;
         st_d.upstream = upstream_port; // RULE10
         st_d.slot_impl = `MSC_SLOT_DN_RST; // RULE11
         st_d.mps = (port_count <= `MSC_SMALL_PORTS) ? `MSC_MPS_2048 :
            `MSC_MPS_1024; // RULE13
      end else if (preload_wr) begin
         if (preload_addr == `MSC_OFF_PCIE_CAP && !st_q.upstream) begin
            st_d.slot_impl = preload_wdata[`MSC_SLOT_BIT]; // RULE11
         end
         if (preload_addr == `MSC_OFF_DEV_CAP && mps_valid(pre_mps)) begin
            st_d.mps = pre_mps; // RULE14
         end
      end
      if (cfg_rd) begin
         if (sts_hit) begin
            st_d.rdata = {26'h0, sif.status}; // RULE6
         end else if (cfg_addr == `MSC_OFF_PCIE_CAP) begin
            st_d.rdata = cap_hdr;
         end else if (cfg_addr == `MSC_OFF_DEV_CAP) begin
            st_d.rdata = dev_cap;
         end else begin
            st_d.rdata = '0; // RULE19
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign cfg_rdata = st_q.rdata;
   assign cfg_rd_ack = st_q.rd_ack;
   assign cfg_wr_ack = st_q.wr_ack;

   sequence s_rd_hdr;
      cfg_rd && cfg_addr == `MSC_OFF_PCIE_CAP;
   endsequence

   sequence s_rd_dev;
      cfg_rd && cfg_addr == `MSC_OFF_DEV_CAP;
   endsequence

   sequence s_rd_sts;
      cfg_rd && sts_hit;
   endsequence

   property p_hdr_ids;
      @(posedge core_clk) disable iff (!rst_b)
         s_rd_hdr |=> cfg_rd_ack && cfg_rdata[15:0] == 16'ha410;
   endproperty
   a_hdr_ids: assert property (p_hdr_ids) // RULE8
      else $error("capability identifier or next pointer wrong");

   property p_hdr_ver;
      @(posedge core_clk) disable iff (!rst_b)
         s_rd_hdr |=> cfg_rdata[19:16] == 4'h2 && cfg_rdata[31:25] == 7'h00;
   endproperty
   a_hdr_ver: assert property (p_hdr_ver) // RULE12
      else $error("capability version or message number wrong");

   property p_hdr_type;
      @(posedge core_clk) disable iff (!rst_b)
         (s_rd_hdr and st_q.strap_done) |=> cfg_rdata[23:20] ==
            ($past(st_q.upstream) ? 4'h5 : 4'h6) &&
            !(cfg_rdata[24] && $past(st_q.upstream));
   endproperty
   a_hdr_type: assert property (p_hdr_type) // RULE10
      else $error("port type or upstream slot bit wrong");

   property p_dev_fixed;
      @(posedge core_clk) disable iff (!rst_b)
         s_rd_dev |=> cfg_rdata[14:3] == 12'h000 && cfg_rdata[31:16] == 16'h0;
   endproperty
   a_dev_fixed: assert property (p_dev_fixed) // RULE16
      else $error("device capability fixed fields not zero");

   property p_mps_default;
      @(posedge core_clk) disable iff (!rst_b)
         (!st_q.strap_done && port_count > 4'h6) |=> st_q.mps == 3'h3;
   endproperty
   a_mps_default: assert property (p_mps_default) // RULE13
      else $error("payload default wrong for more than six ports");

   property p_mps_legal;
      @(posedge core_clk) disable iff (!rst_b)
         st_q.strap_done |-> st_q.mps <= 3'h4;
   endproperty
   a_mps_legal: assert property (p_mps_legal) // RULE14
      else $error("illegal payload code held");

   property p_sts_upper;
      @(posedge core_clk) disable iff (!rst_b)
         s_rd_sts |=> cfg_rd_ack && cfg_rdata[31:6] == 26'h0 &&
            cfg_rdata[5:0] == $past(sif.status);
   endproperty
   a_sts_upper: assert property (p_sts_upper) // RULE18
      else $error("status read wrong at its current offset");

   property p_wr_no_effect;
      @(posedge core_clk) disable iff (!rst_b)
         (cfg_wr && !preload_wr && st_q.strap_done) |=>
            $stable(st_q.mps) && $stable(st_q.slot_impl) ##1 1'b1;
   endproperty
   a_wr_no_effect: assert property (p_wr_no_effect) // RULE19
      else $error("configuration write changed register state");

   property p_rd_wins;
      @(posedge core_clk) disable iff (!rst_b)
         cfg_rd |=> cfg_rd_ack && !cfg_wr_ack;
   endproperty
   a_rd_wins: assert property (p_rd_wins) // RULE19
      else $error("read strobe not answered by a read acknowledge alone");

   property p_wr_ack;
      @(posedge core_clk) disable iff (!rst_b)
         (cfg_wr && !cfg_rd) |=> cfg_wr_ack && !cfg_rd_ack;
   endproperty
   a_wr_ack: assert property (p_wr_ack) // RULE19
      else $error("write strobe not answered by a write acknowledge");

   property p_rdata_hold;
      @(posedge core_clk) disable iff (!rst_b)
         !cfg_rd |=> $stable(cfg_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) // RULE19
      else $error("read data changed without a read");

   property p_unmapped_zero;
      @(posedge core_clk) disable iff (!rst_b)
         (cfg_rd && !sts_hit && cfg_addr != `MSC_OFF_PCIE_CAP &&
            cfg_addr != `MSC_OFF_DEV_CAP) |=> cfg_rdata == 32'h0;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero) // RULE19
      else $error("unmapped offset did not read zero");

   property p_sts_32;
      @(posedge core_clk) disable iff (!rst_b)
         (cfg_rd && !cap64 && cfg_addr == `MSC_OFF_STS_32) |=>
            cfg_rdata == {26'h0, $past(sif.status)};
   endproperty
   a_sts_32: assert property (p_sts_32) // RULE18
      else $error("status not shown at the 32-bit offset");

   property p_sts_64_gone;
      @(posedge core_clk) disable iff (!rst_b)
         (cfg_rd && !cap64 && cfg_addr == `MSC_OFF_STS_64) |=> cfg_rdata == 0;
   endproperty
   a_sts_64_gone: assert property (p_sts_64_gone) // RULE18
      else $error("status still shown at the 64-bit offset");

   property p_strap_kept;
      @(posedge core_clk) disable iff (!rst_b)
         st_q.strap_done |=> st_q.strap_done && $stable(st_q.upstream);
   endproperty
   a_strap_kept: assert property (p_strap_kept) // RULE10
      else $error("port type changed after reset");

   property p_type_capture;
      @(posedge core_clk) disable iff (!rst_b)
         !st_q.strap_done |=> st_q.upstream == $past(upstream_port);
   endproperty
   a_type_capture: assert property (p_type_capture) // RULE10
      else $error("port type strap not captured after reset");

   property p_slot_default;
      @(posedge core_clk) disable iff (!rst_b)
         !st_q.strap_done |=> st_q.slot_impl;
   endproperty
   a_slot_default: assert property (p_slot_default) // RULE11
      else $error("slot implemented did not default to one");

   property p_slot_clear;
      @(posedge core_clk) disable iff (!rst_b)
         (preload_wr && st_q.strap_done && !st_q.upstream &&
            preload_addr == `MSC_OFF_PCIE_CAP &&
            !preload_wdata[`MSC_SLOT_BIT]) |=> !st_q.slot_impl;
   endproperty
   a_slot_clear: assert property (p_slot_clear) // RULE11
      else $error("preload did not clear slot implemented");

   property p_slot_up_hold;
      @(posedge core_clk) disable iff (!rst_b)
         st_q.upstream |=> $stable(st_q.slot_impl);
   endproperty
   a_slot_up_hold: assert property (p_slot_up_hold) // RULE11
      else $error("slot implemented changed on an upstream port");

   property p_mps_small;
      @(posedge core_clk) disable iff (!rst_b)
         (!st_q.strap_done && port_count <= 4'h6) |=> st_q.mps == 3'h4;
   endproperty
   a_mps_small: assert property (p_mps_small) // RULE13
      else $error("payload default wrong for six or fewer ports");

   property p_mps_bad_code;
      @(posedge core_clk) disable iff (!rst_b)
         (preload_wr && st_q.strap_done && pre_mps > 3'h4) |=>
            $stable(st_q.mps);
   endproperty
   a_mps_bad_code: assert property (p_mps_bad_code) // RULE14
      else $error("invalid payload code was stored");

   property p_mps_preload;
      @(posedge core_clk) disable iff (!rst_b)
         (preload_wr && st_q.strap_done && preload_addr == `MSC_OFF_DEV_CAP &&
            pre_mps <= 3'h4) |=> st_q.mps == $past(pre_mps);
   endproperty
   a_mps_preload: assert property (p_mps_preload) // RULE14
      else $error("valid payload code preload not stored");

   property p_dev_mps_read;
      @(posedge core_clk) disable iff (!rst_b)
         s_rd_dev |=> cfg_rdata[2:0] == $past(st_q.mps) && cfg_rdata[15];
   endproperty
   a_dev_mps_read: assert property (p_dev_mps_read) // RULE13
      else $error("device capability payload field read wrong");
endmodule // msc_cap_regs
`default_nettype wire

// [msc_cap_regs_tb.sv]
// Purpose: Self-checking bench for the MSI pending status and capability
//          register block, driven through its configuration strobes.
// Assumes: Inputs change on the falling edge of core_clk.
// Notes:   Straps are varied across resets to cover both port kinds.
`timescale 1ns/10ps
`default_nettype none
`include "msc_defines.svh"
module msc_cap_regs_tb;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic cfg_rd = 1'b0;
   logic cfg_wr = 1'b0;
   logic [11:0] cfg_addr = 12'h000;
   logic [31:0] cfg_wdata = 32'h0;
   logic [31:0] cfg_rdata;
   logic cfg_rd_ack;
   logic cfg_wr_ack;
   logic preload_wr = 1'b0;
   logic [11:0] preload_addr = 12'h000;
   logic [31:0] preload_wdata = 32'h0;
   logic [31:0] msi_ctrl_word = 32'h0;
   logic [4:0] md = 5'h00;
   logic upstream_port = 1'b0;
   logic [3:0] port_count = 4'hc;
   logic [7:0] ev = 8'h00;
   int err_total = 0;
   int n_compared = 0;
   int cyc = 0;
   logic [4:0] modes [5] = '{5'b01100, 5'b01000, 5'b00010, 5'b10001,
      5'b10000};

   always #20 core_clk = ~core_clk;

   msc_cap_regs uut (.core_clk(core_clk), .rst_b(rst_b), .cfg_rd(cfg_rd),
      .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
      .cfg_rdata(cfg_rdata), .cfg_rd_ack(cfg_rd_ack),
      .cfg_wr_ack(cfg_wr_ack), .preload_wr(preload_wr),
      .preload_addr(preload_addr), .preload_wdata(preload_wdata),
      .msi_ctrl_word(msi_ctrl_word), .virtual_switch_mode(md[4]),
      .bridged_isolation_mode(md[3]), .isolation_vif(md[2]),
      .port_zero(md[1]), .upstream_port(upstream_port),
      .mgmt_port(md[0]), .port_count(port_count), .hp_evt(ev[0]),
      .link_err_evt(ev[1]), .link_dll_evt(ev[2]), .link_msg_evt(ev[3]),
      .gpio_evt(ev[4]), .db_evt(ev[5]), .mdb_evt(ev[6]), .mls_evt(ev[7]));

   task automatic conclude();
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 15000) begin
         err_total++;
         conclude();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One-cycle read strobe; ack and data are present in the next cycle.
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      @(negedge core_clk);
      cfg_rd = 1'b1;
      cfg_addr = a;
      @(negedge core_clk);
      cfg_rd = 1'b0;
      chk({31'h0, cfg_rd_ack}, 32'h1);
      chk(cfg_rdata, exp);
   endtask

   task automatic wr_chk(input logic [11:0] a, input logic rd_too);
      @(negedge core_clk);
      cfg_wr = 1'b1;
      cfg_rd = rd_too;
      cfg_addr = a;
      cfg_wdata = 32'hffff_ffff;
      @(negedge core_clk);
      cfg_wr = 1'b0;
      cfg_rd = 1'b0;
      chk({31'h0, cfg_wr_ack}, {31'h0, ~rd_too});
   endtask

   task automatic preload(input logic [11:0] a, input logic [31:0] d);
      @(negedge core_clk);
      preload_wr = 1'b1;
      preload_addr = a;
      preload_wdata = d;
      @(negedge core_clk);
      preload_wr = 1'b0;
   endtask

   task automatic do_reset(input logic up, input logic [3:0] pc);
      @(negedge core_clk);
      rst_b = 1'b0;
      upstream_port = up;
      port_count = pc;
      repeat (6) @(negedge core_clk);
      rst_b = 1'b1;
      repeat (3) @(negedge core_clk);
   endtask

   function automatic logic [31:0] hdr(input logic up, input logic slot);
      return {2'h0, 5'h00, slot, (up ? 4'h5 : 4'h6), 4'h2, 8'ha4, 8'h10};
   endfunction

   function automatic logic [31:0] exp_sts(input logic [2:0] m,
      input logic [4:0] mo, input logic up, input logic [7:0] e);
      logic vs, nt, vif, pz, mg;
      logic [31:0] r;
      {vs, nt, vif, pz, mg} = mo;
      r = 32'h0;
      r[0] = e[0] && (m == 3'h2 || m == 3'h3);
      r[1] = !vs && nt && vif && m >= 3'h1 && m <= 3'h3 && (|e[3:1]);
      r[2] = e[4] && (m == 3'h2 || m == 3'h3) && (vs ? up : pz);
      r[3] = !vs && nt && vif && m == 3'h3 && e[5];
      r[4] = vs && (up || mg) && m == 3'h3 && e[6];
      r[5] = vs && mg && m == 3'h3 && e[7];
      return r;
   endfunction

   // Every mode, vector count and single event, then all events at once.
   task automatic sts_sweep(input logic up);
      for (int i = 0; i < 5; i++) begin
         for (int m = 0; m < 8; m++) begin
            for (int k = 0; k < 9; k++) begin
               @(negedge core_clk);
               md = modes[i];
               msi_ctrl_word = {8'h00, 1'b1, 3'(m), 20'h0};
               ev = (k == 8) ? 8'hff : 8'(1 << k);
               repeat (2) @(negedge core_clk);
               rd_chk(`MSC_OFF_STS_64, exp_sts(3'(m), md, up, ev));
            end
         end
      end
   endtask

   initial begin
      do_reset(1'b0, 4'hc);
      rd_chk(`MSC_OFF_PCIE_CAP, hdr(1'b0, 1'b1));
      rd_chk(`MSC_OFF_DEV_CAP, 32'h0000_8003);
      rd_chk(12'h070, 32'h0);
      wr_chk(`MSC_OFF_PCIE_CAP, 1'b0);
      wr_chk(`MSC_OFF_DEV_CAP, 1'b1);
      rd_chk(`MSC_OFF_PCIE_CAP, hdr(1'b0, 1'b1));
      rd_chk(`MSC_OFF_DEV_CAP, 32'h0000_8003);
      preload(`MSC_OFF_PCIE_CAP, 32'h0);
      rd_chk(`MSC_OFF_PCIE_CAP, hdr(1'b0, 1'b0));
      for (int c = 0; c < 8; c++) begin
         preload(`MSC_OFF_DEV_CAP, 32'(7 - c));
         rd_chk(`MSC_OFF_DEV_CAP, {16'h0, 1'b1, 12'h0,
            ((7 - c) > 4) ? 3'h3 : 3'(7 - c)});
      end
      sts_sweep(1'b0);
      @(negedge core_clk);
      md = 5'b10001;
      ev = 8'hff;
      msi_ctrl_word = {8'h00, 1'b0, 3'h3, 20'h0};
      repeat (2) @(negedge core_clk);
      rd_chk(`MSC_OFF_STS_32, exp_sts(3'h3, md, 1'b0, ev));
      rd_chk(`MSC_OFF_STS_64, 32'h0);
      wr_chk(`MSC_OFF_STS_32, 1'b0);
      rd_chk(`MSC_OFF_STS_32, exp_sts(3'h3, md, 1'b0, ev));
      do_reset(1'b1, 4'h6);
      rd_chk(`MSC_OFF_PCIE_CAP, hdr(1'b1, 1'b0));
      rd_chk(`MSC_OFF_DEV_CAP, 32'h0000_8004);
      preload(`MSC_OFF_PCIE_CAP, 32'h0100_0000);
      rd_chk(`MSC_OFF_PCIE_CAP, hdr(1'b1, 1'b0));
      sts_sweep(1'b1);
      do_reset(1'b0, 4'h7);
      rd_chk(`MSC_OFF_DEV_CAP, 32'h0000_8003);
      conclude();
   end
endmodule // msc_cap_regs_tb
`default_nettype wire

// [msc_defines.svh]
// Purpose: Offsets, field positions, reset values and codes of the MSI
//          pending-status and PCI Express capability register block.
// Assumes: Byte offsets within the port's configuration space.
// Notes:   Included by the design modules; definitions only.
//
// Behaviour
// RULE1: Bridged-isolation base mode, two or more vectors: bit 1 shows link-side error pending.
// RULE2: Bit 1 also shows link state changes and dropped fatal or non-fatal messages.
// RULE3: Bit 2 shows GPIO pending on port 0 base or VS upstream, vectors 010b/011b.
// RULE4: Bit 3 shows isolation doorbell pending only in base bridged-isolation mode, 011b.
// RULE5: Bit 4 shows management doorbell on VS upstream or management port, 011b.
// RULE6: Bit 5 shows management link status on management port, 011b; bits 31:6 zero.
// RULE7: Capability identifier, bits 7:0, reads 10h.
// RULE8: Next capability pointer, bits 15:8, reads A4h.
// RULE9: Capability version, bits 19:16, reads 2h.
// RULE10: Port type, bits 23:20, fixed at reset: 5h upstream, 6h downstream.
// RULE11: Slot-implemented bit 24 defaults 1 downstream, preload may clear; upstream zero.
// RULE12: Interrupt message number, bits 29:25, reads zero.
// RULE13: Maximum payload supported defaults 100b up to six ports, else 011b.
// RULE14: Payload codes 000b to 100b mean 128 to 2048 bytes; others invalid.
// RULE15: Extended tag bit 5 reads 0; phantom functions bits 4:3 read zero.
// RULE16: L0s latency bits 8:6 and L1 latency bits 11:9 read 000b.
// RULE17: Enabled vector count sits at MSI control bits 22:20 and selects bits.
// RULE18: Status register moves from 5Ch to 58h when 64-bit capable is clear.
// RULE19: Reserved bits read zero; writes to read-only fields change nothing.
`ifndef MSC_DEFINES_SVH
`define MSC_DEFINES_SVH

`define MSC_OFF_STS_64 12'h05c
`define MSC_OFF_STS_32 12'h058
`define MSC_OFF_PCIE_CAP 12'h068
`define MSC_OFF_DEV_CAP 12'h06c

`define MSC_MME_MSB 22
`define MSC_MME_LSB 20
`define MSC_CAP64_BIT 23
`define MSC_MME_ONE 3'h0
`define MSC_MME_TWO 3'h1
`define MSC_MME_FOUR 3'h2
`define MSC_MME_EIGHT 3'h3
`define MSC_STS_BITS 6

`define MSC_CAP_ID 8'h10
`define MSC_NEXT_PTR 8'ha4
`define MSC_CAP_VER 4'h2
`define MSC_TYPE_UP 4'h5
`define MSC_TYPE_DN 4'h6
`define MSC_MSG_NUM 5'h00
`define MSC_SLOT_BIT 24
`define MSC_SLOT_DN_RST 1'b1

`define MSC_MPS_2048 3'h4
`define MSC_MPS_1024 3'h3
`define MSC_MPS_MAX_CODE 3'h4
`define MSC_SMALL_PORTS 4'h6
`define MSC_PHANTOM 2'h0
`define MSC_EXT_TAG 1'b0
`define MSC_LAT_L0S 3'h0
`define MSC_LAT_L1 3'h0
`define MSC_DEVCAP_RSVD 3'h0
`define MSC_ROLE_ERR 1'b1

`endif

// [msc_pend_status.sv]
// Purpose: Qualifies the six interrupt category levels into the pending
//          status bits of the Msi_pending_status register.
// Assumes: Event levels are held by their sources until serviced.
// Notes:   Status follows its inputs one clock later.
`timescale 1ns/10ps
`default_nettype none
`include "msc_defines.svh"
module msc_pend_status import msc_pkg::*; (
   input wire logic core_clk,
   input wire logic rst_b,
   msc_sts_if.sts sif
);
   msc_pend_s st_q;
   msc_pend_s st_d;
   logic base;
   logic mme_2up;
   logic mme_4up;
   logic mme_8;

   always_comb begin
      base = !sif.vs_mode;
      mme_8 = (sif.mme == `MSC_MME_EIGHT);
      mme_4up = (sif.mme == `MSC_MME_FOUR) || mme_8;
      mme_2up = (sif.mme == `MSC_MME_TWO) || mme_4up; // RULE17
      st_d = '0;
      st_d.pend[0] = mme_4up && sif.hp_evt;
      st_d.pend[1] = base && sif.nt_mode && sif.nt_vif && mme_2up &&
         (sif.link_err_evt || sif.link_dll_evt || sif.link_msg_evt); // RULE1 RULE2
      st_d.pend[2] = mme_4up && sif.gpio_evt &&
         ((base && sif.port_zero) || (sif.vs_mode && sif.upstream)); // RULE3
      st_d.pend[3] = base && sif.nt_mode && sif.nt_vif && mme_8 &&
         sif.db_evt; // RULE4
      st_d.pend[4] = sif.vs_mode && (sif.upstream || sif.mgmt) && mme_8 &&
         sif.mdb_evt; // RULE5
      st_d.pend[5] = sif.vs_mode && sif.mgmt && mme_8 && sif.mls_evt; // RULE6
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign sif.status = st_q.pend;

   sequence s_link_evt;
      !sif.vs_mode && sif.nt_mode && sif.nt_vif &&
         (sif.mme == `MSC_MME_TWO) && sif.link_dll_evt;
   endsequence

   property p_link_dll_sets;
      @(posedge core_clk) disable iff (!rst_b)
         s_link_evt |=> sif.status[1];
   endproperty
   a_link_dll_sets: assert property (p_link_dll_sets) // RULE2
      else $error("link state change did not set pending bit 1");

   property p_bit1_rsvd;
      @(posedge core_clk) disable iff (!rst_b)
         (sif.vs_mode || sif.mme == `MSC_MME_ONE) |=> !sif.status[1];
   endproperty
   a_bit1_rsvd: assert property (p_bit1_rsvd) // RULE1
      else $error("pending bit 1 set while reserved");

   property p_bit3_only_eight;
      @(posedge core_clk) disable iff (!rst_b)
         (sif.mme != `MSC_MME_EIGHT) |=> !sif.status[3] && !sif.status[4]
            && !sif.status[5];
   endproperty
   a_bit3_only_eight: assert property (p_bit3_only_eight) // RULE4
      else $error("bits 5:3 set with fewer than eight vectors");

   property p_mgmt_link;
      @(posedge core_clk) disable iff (!rst_b)
         (sif.vs_mode && sif.mgmt && sif.mme == `MSC_MME_EIGHT && sif.mls_evt)
            |=> sif.status[5];
   endproperty
   a_mgmt_link: assert property (p_mgmt_link) // RULE6
      else $error("management link event not shown in bit 5");

   property p_gpio_base;
      @(posedge core_clk) disable iff (!rst_b)
         (!sif.vs_mode && !sif.port_zero) |=> !sif.status[2];
   endproperty
   a_gpio_base: assert property (p_gpio_base) // RULE3
      else $error("GPIO pending shown off port 0 in base mode");

   property p_mdb_base;
      @(posedge core_clk) disable iff (!rst_b)
         !sif.vs_mode |=> !sif.status[4];
   endproperty
   a_mdb_base: assert property (p_mdb_base) // RULE5
      else $error("management doorbell shown in base mode");
endmodule // msc_pend_status
`default_nettype wire

// [msc_pkg.sv]
// Purpose: Types of the Msi_pending_status and capability register block.
// Assumes: Widths match the offsets and fields of msc_defines.svh.
// Notes:   Each module keeps its whole state in one of these structs.
package msc_pkg;

   typedef struct packed {
      logic [5:0] pend;
   } msc_pend_s;

   typedef struct packed {
      logic strap_done;
      logic upstream;
      logic [2:0] mps;
      logic slot_impl;
      logic rd_ack;
      logic wr_ack;
      logic [31:0] rdata;
   } msc_regs_s;

endpackage

// [msc_sts_if.sv]
// Purpose: Carries mode, vector count and event levels to the pending
//          status logic and the status bits back.
// Assumes: All signals on core_clk.
// Notes:   No clocking block.
`timescale 1ns/10ps
`default_nettype none
interface msc_sts_if;
   logic [2:0] mme;
   logic vs_mode;
   logic nt_mode;
   logic nt_vif;
   logic port_zero;
   logic upstream;
   logic mgmt;
   logic hp_evt;
   logic link_err_evt;
   logic link_dll_evt;
   logic link_msg_evt;
   logic gpio_evt;
   logic db_evt;
   logic mdb_evt;
   logic mls_evt;
   logic [5:0] status;

   modport src (output mme, vs_mode, nt_mode, nt_vif, port_zero, upstream,
      mgmt, hp_evt, link_err_evt, link_dll_evt, link_msg_evt, gpio_evt,
      db_evt, mdb_evt, mls_evt, input status);
   modport sts (input mme, vs_mode, nt_mode, nt_vif, port_zero, upstream,
      mgmt, hp_evt, link_err_evt, link_dll_evt, link_msg_evt, gpio_evt,
      db_evt, mdb_evt, mls_evt, output status);
endinterface
`default_nettype wire
